/* File: hdl/ovpd_pkg.sv */
// Constants for the overvoltage protection and dead time stage.
// Assumes a 20 MHz system clock and a plain one-cycle register port.
// Contract
// - Monitor one counts as overvoltage when enabled
// - Monitor zero counts as overvoltage when enabled
// - Two-bit mode selects forced output pattern
// - Forced levels follow upper and lower polarity
// - Emergency mode wins when both conditions present
// - Select bit routes port or monitor input
// - Monitor source bypasses the noise filter
// - Release bit enables automatic protection exit
// - Exit at next period buffer update
// - Enable bit turns protection on or off
// - Disable only after two keys then clear
// - Status bit shows selected input level
// - Status bit shows protected state, resets 0
// - Dead time delays turn-on at each swap
// - Eight-bit dead time, 200 ns step
// - Upper and lower polarity chosen independently
// - Port input filtered low for count times sixteen
// - Entering protection raises an interrupt request
// - Never release while input still low; clearing enable releases regardless of input
package ovpd_pkg;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h1;
   localparam logic [3:0] ADDR_KEY = 4'h2;
   localparam logic [3:0] ADDR_DEAD = 4'h3;
   localparam logic [3:0] ADDR_OUTSET = 4'h4;
   localparam int B_EN = 0;
   localparam int B_RS = 1;
   localparam int B_ISEL = 2;
   localparam int B_MD0 = 3;
   localparam int B_AD0 = 5;
   localparam int B_AD1 = 6;
   localparam int B_CNT0 = 8;
   localparam int B_POLL = 0;
   localparam int B_POLH = 1;
   localparam int B_EMD0 = 2;
   localparam logic [7:0] KEY1 = 8'h5A;
   localparam logic [7:0] KEY2 = 8'hA5;
   localparam logic [1:0] MD_NONE = 2'h0;
   localparam logic [1:0] MD_UPON = 2'h1;
   localparam logic [1:0] MD_LOON = 2'h2;
   localparam logic [1:0] MD_OFF = 2'h3;
   localparam int FILT_STEP = 16;
   localparam int SYS_MHZ = 20;
   localparam int DT_STEP_NS = 200;
   localparam int DT_STEP_CYC = (DT_STEP_NS * SYS_MHZ) / 1000;
   typedef enum logic [1:0] {KS_IDLE, KS_ONE, KS_TWO} ovpd_key_t;
endpackage

/* File: hdl/ovpd_top.sv */
// Overvoltage protection, dead time and polarity stage for six phase outputs.
// Assumes PWM levels, period update pulse and emergency inputs come from the same clock.
`timescale 1ns/1ps
module ovpd_top #(
   parameter int DT_BITS = 8
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Pins and monitors
   input wire logic OVV_PIN_N,
   input wire logic ADC_MON0,
   input wire logic ADC_MON1,
   // PWM core side
   input wire logic [2:0] PWM_UPPER,
   input wire logic PERIOD_UPDATE,
   input wire logic EMG_ACTIVE,
   input wire logic [1:0] EMG_MODE,
   // Outputs
   output logic [2:0] UPPER_OUT,
   output logic [2:0] LOWER_OUT,
   output logic OVV_IRQ
);

   typedef struct packed {
      logic [1:0] pin_sync;
      logic [8:0] ctrl;
      logic [3:0] cnt;
      logic [7:0] dead;
      logic [3:0] outset;
      ovpd_pkg::ovpd_key_t key;
      logic [7:0] filt;
      logic prot;
      logic irq;
      logic [31:0] rdata;
      logic [2:0] up_prev;
      logic [2:0][DT_BITS+4:0] dcnt;
      logic [2:0] up_out;
      logic [2:0] lo_out;
   } ovpd_state_t;

   ovpd_state_t s_r;
   ovpd_state_t s_nxt;

   logic en, rs, isel;
   logic [1:0] md, act_md;
   logic adc_ovv, pin_low, ovv_in, ovv_det;
   logic [7:0] filt_len;
   logic [2:0] want_up, want_lo;
   logic [2:0] up_eff, lo_eff;
   logic polh, poll;

   always_comb begin
      s_nxt = s_r;
      en = s_r.ctrl[ovpd_pkg::B_EN];
      rs = s_r.ctrl[ovpd_pkg::B_RS];
      isel = s_r.ctrl[ovpd_pkg::B_ISEL];
      md = s_r.ctrl[ovpd_pkg::B_MD0 +: 2];
      poll = s_r.outset[ovpd_pkg::B_POLL];
      polh = s_r.outset[ovpd_pkg::B_POLH];
      s_nxt.pin_sync = {s_r.pin_sync[0], OVV_PIN_N};
      pin_low = ~s_r.pin_sync[1];
      // Monitors are active high; they skip the filter entirely
      adc_ovv = (s_r.ctrl[ovpd_pkg::B_AD1] & ADC_MON1)
              | (s_r.ctrl[ovpd_pkg::B_AD0] & ADC_MON0);
      // Zero count acts as one
      filt_len = (s_r.cnt == 4'h0) ? 8'(ovpd_pkg::FILT_STEP)
               : 8'(s_r.cnt * ovpd_pkg::FILT_STEP);
      if (pin_low) begin
         if (s_r.filt != 8'hFF)
            s_nxt.filt = s_r.filt + 8'h01;
      end else begin
         s_nxt.filt = 8'h00;
      end
      ovv_in = isel ? adc_ovv : pin_low;
      ovv_det = isel ? adc_ovv
              : (pin_low && s_r.filt >= filt_len - 8'h01);
      s_nxt.irq = 1'b0;
      if (en && ovv_det && !s_r.prot) begin
         s_nxt.prot = 1'b1;
         s_nxt.irq = 1'b1;
      end else if (s_r.prot && !en) begin
         s_nxt.prot = 1'b0;
      end else if (s_r.prot && rs && PERIOD_UPDATE && !ovv_in) begin
         s_nxt.prot = 1'b0;
      end
      // Register writes
      if (WR) begin
         case (ADDR)
            ovpd_pkg::ADDR_CTRL: begin
               s_nxt.cnt = WDATA[ovpd_pkg::B_CNT0 +: 4];
               s_nxt.ctrl[8:1] = WDATA[8:1];
               s_nxt.ctrl[7] = 1'b0;
               // Clearing enable needs the key pair just before
               if (WDATA[ovpd_pkg::B_EN] || s_r.key == ovpd_pkg::KS_TWO)
                  s_nxt.ctrl[ovpd_pkg::B_EN] = WDATA[ovpd_pkg::B_EN];
            end
            ovpd_pkg::ADDR_DEAD: s_nxt.dead = WDATA[7:0];
            ovpd_pkg::ADDR_OUTSET: s_nxt.outset = WDATA[3:0];
            default: ;
         endcase
         // Any write breaks the key sequence unless it is the next step
         if (ADDR == ovpd_pkg::ADDR_KEY && WDATA[7:0] == ovpd_pkg::KEY1)
            s_nxt.key = ovpd_pkg::KS_ONE;
         else if (ADDR == ovpd_pkg::ADDR_KEY && WDATA[7:0] == ovpd_pkg::KEY2
                  && s_r.key == ovpd_pkg::KS_ONE)
            s_nxt.key = ovpd_pkg::KS_TWO;
         else
            s_nxt.key = ovpd_pkg::KS_IDLE;
      end
      // Read data
      s_nxt.rdata = 32'h0000_0000;
      if (RD) begin
         case (ADDR)
            ovpd_pkg::ADDR_CTRL: s_nxt.rdata = {20'h00000, s_r.cnt, 1'h0,
                                                s_r.ctrl[6:0]};
            ovpd_pkg::ADDR_STAT: s_nxt.rdata = {30'h0, ~ovv_in, s_r.prot};
            ovpd_pkg::ADDR_DEAD: s_nxt.rdata = {24'h000000, s_r.dead};
            ovpd_pkg::ADDR_OUTSET: s_nxt.rdata = {28'h0000000, s_r.outset};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // Emergency pattern overrides overvoltage pattern
      act_md = EMG_ACTIVE ? EMG_MODE : (s_r.prot ? md : ovpd_pkg::MD_NONE);
      case (act_md)
         ovpd_pkg::MD_UPON: begin
            want_up = 3'b111;
            want_lo = 3'b000;
         end
         ovpd_pkg::MD_LOON: begin
            want_up = 3'b000;
            want_lo = 3'b111;
         end
         ovpd_pkg::MD_OFF: begin
            want_up = 3'b000;
            want_lo = 3'b000;
         end
         default: begin
            want_up = PWM_UPPER;
            want_lo = ~PWM_UPPER;
         end
      endcase
      s_nxt.up_prev = want_up;
      for (int i = 0; i < 3; i++) begin
         // Any change of the phase restarts the dead count; the rising side waits
         if (want_up[i] != s_r.up_prev[i] || want_lo[i] == want_up[i])
            s_nxt.dcnt[i] = (DT_BITS+5)'(s_r.dead * ovpd_pkg::DT_STEP_CYC);
         else if (s_r.dcnt[i] != '0)
            s_nxt.dcnt[i] = s_r.dcnt[i] - 1'b1;
         up_eff[i] = want_up[i] && (s_r.dcnt[i] == '0 || want_lo[i] == want_up[i]);
         lo_eff[i] = want_lo[i] && (s_r.dcnt[i] == '0 || want_lo[i] == want_up[i]);
         if (want_up[i] != s_r.up_prev[i]) begin
            up_eff[i] = 1'b0;
            lo_eff[i] = 1'b0;
         end
      end
      s_nxt.up_out = polh ? up_eff : ~up_eff;
      s_nxt.lo_out = poll ? lo_eff : ~lo_eff;
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_r <= '0;
         s_r.pin_sync <= 2'b11;
         s_r.outset <= 4'h3;
         s_r.up_prev <= 3'b000;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign RDATA = s_r.rdata;
   assign UPPER_OUT = s_r.up_out;
   assign LOWER_OUT = s_r.lo_out;
   assign OVV_IRQ = s_r.irq;

   property p_irq_on_entry;
      @(posedge CLOCK) disable iff (!RESET_N)
      $rose(s_r.prot) |-> s_r.irq;
   endproperty
   a_irq_on_entry: assert property (p_irq_on_entry) else $error("no irq on entry");

   property p_no_release_low;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_r.prot && en && ovv_in |=> s_r.prot;
   endproperty
   a_no_release_low: assert property (p_no_release_low) else $error("released while low");

   property p_no_auto_release;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_r.prot && en && !rs && !(WR && ADDR == ovpd_pkg::ADDR_CTRL) |=> s_r.prot;
   endproperty
   a_no_auto_release: assert property (p_no_auto_release) else $error("auto release off");

   property p_release_period;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_r.prot && en && rs && !PERIOD_UPDATE |=> s_r.prot;
   endproperty
   a_release_period: assert property (p_release_period) else $error("release off period");

   property p_key_guard;
      @(posedge CLOCK) disable iff (!RESET_N)
      WR && ADDR == ovpd_pkg::ADDR_CTRL && !WDATA[0] && s_r.key != ovpd_pkg::KS_TWO && en
      |=> en;
   endproperty
   a_key_guard: assert property (p_key_guard) else $error("unkeyed disable");

   property p_status_read;
      @(posedge CLOCK) disable iff (!RESET_N)
      RD && ADDR == ovpd_pkg::ADDR_STAT |=> RDATA[0] == $past(s_r.prot);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status mismatch");

   property p_all_off;
      @(posedge CLOCK) disable iff (!RESET_N)
      act_md == ovpd_pkg::MD_OFF |=> UPPER_OUT == {3{~polh}} && LOWER_OUT == {3{~poll}};
   endproperty
   a_all_off: assert property (p_all_off) else $error("all off pattern wrong");

   property p_no_overlap;
      @(posedge CLOCK) disable iff (!RESET_N)
      !(up_eff[0] && lo_eff[0] && want_up[0] != want_lo[0]);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("phase overlap");

   // Entry and release of the protected state
   property p_irq_pulse;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_r.irq |=> !s_r.irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");

   property p_entry;
      @(posedge CLOCK) disable iff (!RESET_N)
      en && ovv_det && !s_r.prot |=> s_r.prot && s_r.irq;
   endproperty
   a_entry: assert property (p_entry) else $error("no entry on detect");

   property p_auto_release;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_r.prot && en && rs && PERIOD_UPDATE && !ovv_in |=> !s_r.prot;
   endproperty
   a_auto_release: assert property (p_auto_release) else $error("no auto release");

   property p_adc_direct;
      @(posedge CLOCK) disable iff (!RESET_N)
      en && isel && adc_ovv && !s_r.prot |=> s_r.prot;
   endproperty
   a_adc_direct: assert property (p_adc_direct) else $error("monitor not direct");

   property p_mon1_gate;
      @(posedge CLOCK) disable iff (!RESET_N)
      en && isel && !s_r.ctrl[ovpd_pkg::B_AD1] && !(s_r.ctrl[ovpd_pkg::B_AD0] && ADC_MON0)
      && !s_r.prot |=> !s_r.prot;
   endproperty
   a_mon1_gate: assert property (p_mon1_gate) else $error("monitor one not gated");

   property p_mon0_gate;
      @(posedge CLOCK) disable iff (!RESET_N)
      en && isel && !s_r.ctrl[ovpd_pkg::B_AD0] && !(s_r.ctrl[ovpd_pkg::B_AD1] && ADC_MON1)
      && !s_r.prot |=> !s_r.prot;
   endproperty
   a_mon0_gate: assert property (p_mon0_gate) else $error("monitor zero not gated");

   property p_port_quiet;
      @(posedge CLOCK) disable iff (!RESET_N)
      en && !isel && !pin_low && !s_r.prot |=> !s_r.prot;
   endproperty
   a_port_quiet: assert property (p_port_quiet) else $error("entry with pin high");

   // Key sequence steps
   sequence s_key_first;
      WR && ADDR == ovpd_pkg::ADDR_KEY && WDATA[7:0] == ovpd_pkg::KEY1;
   endsequence

   sequence s_key_second;
      s_r.key == ovpd_pkg::KS_ONE && WR && ADDR == ovpd_pkg::ADDR_KEY
      && WDATA[7:0] == ovpd_pkg::KEY2;
   endsequence

   property p_key_one;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_key_first |=> s_r.key == ovpd_pkg::KS_ONE;
   endproperty
   a_key_one: assert property (p_key_one) else $error("first key lost");

   property p_key_two;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_key_second |=> s_r.key == ovpd_pkg::KS_TWO;
   endproperty
   a_key_two: assert property (p_key_two) else $error("second key lost");

   property p_unlock;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_key_second ##1 !WR ##1 (WR && ADDR == ovpd_pkg::ADDR_CTRL && !WDATA[ovpd_pkg::B_EN])
      |=> !en;
   endproperty
   a_unlock: assert property (p_unlock) else $error("keyed disable refused");

   // Forced patterns once the dead count has run out
   property p_upper_on;
      @(posedge CLOCK) disable iff (!RESET_N)
      act_md == ovpd_pkg::MD_UPON && s_r.up_prev == 3'b111 && s_r.dcnt == '0
      |=> UPPER_OUT == {3{$past(polh)}} && LOWER_OUT == {3{~$past(poll)}};
   endproperty
   a_upper_on: assert property (p_upper_on) else $error("upper on pattern wrong");

   property p_lower_on;
      @(posedge CLOCK) disable iff (!RESET_N)
      act_md == ovpd_pkg::MD_LOON && s_r.up_prev == 3'b000 && s_r.dcnt == '0
      |=> UPPER_OUT == {3{~$past(polh)}} && LOWER_OUT == {3{$past(poll)}};
   endproperty
   a_lower_on: assert property (p_lower_on) else $error("lower on pattern wrong");

   // Phase U swap: both sides blank, then the incoming side waits out the count
   sequence s_swap;
      want_up[0] != s_r.up_prev[0];
   endsequence

   property p_swap_blank;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_swap |=> UPPER_OUT[0] == ~$past(polh) && LOWER_OUT[0] == ~$past(poll);
   endproperty
   a_swap_blank: assert property (p_swap_blank) else $error("no blank at swap");

   property p_dead_load;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_swap |=> s_r.dcnt[0] == (DT_BITS+5)'($past(s_r.dead) * ovpd_pkg::DT_STEP_CYC);
   endproperty
   a_dead_load: assert property (p_dead_load) else $error("dead count wrong");

   property p_dead_wait;
      @(posedge CLOCK) disable iff (!RESET_N)
      s_swap ##1 (s_r.dcnt[0] != '0 && want_up[0] != want_lo[0] && want_up[0] == s_r.up_prev[0])
      |-> !up_eff[0] && !lo_eff[0];
   endproperty
   a_dead_wait: assert property (p_dead_wait) else $error("turn-on before dead time");

   // Register port read data
   property p_rdata_idle;
      @(posedge CLOCK) disable iff (!RESET_N)
      !RD |=> RDATA == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

   property p_level_read;
      @(posedge CLOCK) disable iff (!RESET_N)
      RD && ADDR == ovpd_pkg::ADDR_STAT |=> RDATA[1] == ~$past(ovv_in);
   endproperty
   a_level_read: assert property (p_level_read) else $error("input level wrong");
endmodule

/* File: tb/ovpd_far.sv */
// Far-side model: overvoltage pin with a pull-up, and a shoot-through watch on the gates.
// Assumes the bench tells it the gate polarity and when the outputs are settled.
`timescale 1ns/1ps
module ovpd_far (
   // Bench side
   input wire logic clock,
   input wire logic pin_low,
   input wire logic watch,
   input wire logic [1:0] pol,
   // Gate side
   input wire logic [2:0] upper_out,
   input wire logic [2:0] lower_out,
   output logic ovv_pin_n,
   output logic overlap
);
   logic [2:0] up_on;
   logic [2:0] lo_on;
   // Detector pulls low on a fault; the pull-up returns the pin high
   assign ovv_pin_n = pin_low ? 1'b0 : 1'b1;
   assign up_on = pol[1] ? upper_out : ~upper_out;
   assign lo_on = pol[0] ? lower_out : ~lower_out;
   initial overlap = 1'b0;
   always @(posedge clock) begin
      if (watch && ((up_on & lo_on) != 3'h0)) begin
         overlap <= 1'b1;
      end
   end
endmodule

/* File: tb/ovpd_top_tb.sv */
// Bench for the overvoltage stage: register tasks and scripted tests.
// Assumes the far-side model drives the pin and watches the gates.
`timescale 1ns/1ps
module ovpd_top_tb;
   logic CLOCK, RESET_N, WR, RD, pin_low, watch, adc0, adc1, pupd, emergency_condition, ovl, irq, pin_n;
   logic [3:0] ADDR;
   logic [31:0] WDATA, RDATA, d;
   logic [2:0] pwm, up, lo;
   logic [1:0] emd, pol;
   int errors, comparisons, irqs;
   ovpd_top u_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .OVV_PIN_N(pin_n), .ADC_MON0(adc0), .ADC_MON1(adc1),
      .PWM_UPPER(pwm), .PERIOD_UPDATE(pupd), .EMG_ACTIVE(emergency_condition), .EMG_MODE(emd),
      .UPPER_OUT(up), .LOWER_OUT(lo), .OVV_IRQ(irq));
   ovpd_far u_far (.clock(CLOCK), .pin_low(pin_low), .watch(watch), .pol(pol),
      .upper_out(up), .lower_out(lo), .ovv_pin_n(pin_n), .overlap(ovl));
   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      if (irq === 1'b1) begin
         irqs++;
      end
   end
   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] v);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a);
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask
   task automatic prot(logic e);
      rd(ovpd_pkg::ADDR_STAT);
      chk("protected", 32'(e), 32'(d[0]));
   endtask
   task automatic unlock();
      wr(ovpd_pkg::ADDR_KEY, {24'h0, ovpd_pkg::KEY1});
      wr(ovpd_pkg::ADDR_KEY, {24'h0, ovpd_pkg::KEY2});
      wr(ovpd_pkg::ADDR_CTRL, 32'h0);
   endtask
   task automatic pulse();
      @(posedge CLOCK);
      pupd <= 1'b1;
      @(posedge CLOCK);
      pupd <= 1'b0;
      repeat (3) @(posedge CLOCK);
   endtask
   function automatic logic [2:0] lev(logic on, logic ah);
      return {3{on ~^ ah}};
   endfunction
   initial begin
      #(50 * 20000);
      errors++;
      close_out();
   end
   initial begin
      {RESET_N, WR, RD, pin_low, watch, adc0, adc1, pupd, emergency_condition} = 9'h0;
      {ADDR, WDATA, pwm, emd} = 41'h0;
      pol = 2'h3;
      repeat (12) @(posedge CLOCK);
      RESET_N <= 1'b1;
      rd(ovpd_pkg::ADDR_STAT);
      chk("status", 32'h2, d);
      rd(ovpd_pkg::ADDR_CTRL);
      chk("control", 32'h0, d);
      rd(4'hF);
      chk("unmapped", 32'h0, d);
      @(posedge CLOCK);
      #1;
      chk("rdata idle", 32'h0, RDATA);
      $display("test reset done");
      wr(ovpd_pkg::ADDR_CTRL, 32'h239);
      rd(ovpd_pkg::ADDR_CTRL);
      chk("control", 32'h239, d);
      adc0 <= 1'b1;
      pin_low <= 1'b1;
      repeat (20) @(posedge CLOCK);
      rd(ovpd_pkg::ADDR_STAT);
      chk("status", 32'h0, d);
      repeat (25) @(posedge CLOCK);
      prot(1'b1);
      chk("outs", 32'h0, 32'({up, lo}));
      wr(ovpd_pkg::ADDR_CTRL, 32'h0);
      pin_low <= 1'b0;
      prot(1'b1);
      adc0 <= 1'b0;
      unlock();
      prot(1'b0);
      $display("test port done");
      for (int m = 1; m < 4; m++) begin
         pol = m[1:0];
         wr(ovpd_pkg::ADDR_OUTSET, 32'(m));
         wr(ovpd_pkg::ADDR_CTRL, 32'h5 | 32'(m << 3) | ((m == 2) ? 32'h40 : 32'h20));
         adc0 <= (m == 2);
         adc1 <= (m != 2);
         repeat (4) @(posedge CLOCK);
         prot(1'b0);
         adc0 <= 1'b1;
         adc1 <= 1'b1;
         repeat (4) @(posedge CLOCK);
         prot(1'b1);
         chk("level", 32'h0, 32'(d[1]));
         chk("outs", 32'({lev(m == 1, pol[1]), lev(m == 2, pol[0])}), 32'({up, lo}));
         {adc0, adc1} <= 2'h0;
         unlock();
      end
      $display("test modes done");
      pol = 2'h3;
      wr(ovpd_pkg::ADDR_OUTSET, 32'h3);
      wr(ovpd_pkg::ADDR_CTRL, 32'h3F);
      adc0 <= 1'b1;
      pulse();
      prot(1'b1);
      adc0 <= 1'b0;
      repeat (4) @(posedge CLOCK);
      prot(1'b1);
      pulse();
      prot(1'b0);
      wr(ovpd_pkg::ADDR_CTRL, 32'h3D);
      adc0 <= 1'b1;
      emergency_condition <= 1'b1;
      emd <= 2'h1;
      repeat (4) @(posedge CLOCK);
      #1;
      chk("outs", 32'h38, 32'({up, lo}));
      emergency_condition <= 1'b0;
      adc0 <= 1'b0;
      pulse();
      prot(1'b1);
      unlock();
      chk("irqs", 32'h6, 32'(irqs));
      $display("test release done");
      wr(ovpd_pkg::ADDR_DEAD, 32'h2);
      repeat (12) @(posedge CLOCK);
      watch <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         pwm <= (k == 0) ? 3'h7 : 3'h0;
         repeat (4) @(posedge CLOCK);
         #1;
         chk("dead", 32'h0, 32'({up, lo}));
         repeat (10) @(posedge CLOCK);
         #1;
         chk("swap", (k == 0) ? 32'h38 : 32'h7, 32'({up, lo}));
      end
      chk("overlap", 32'h0, 32'(ovl));
      $display("test dead time done");
      close_out();
   end
endmodule
